// ==== rtl/gpio_cfg_consts.vh ====
`ifndef GPIO_CFG_CONSTS_VH
`define GPIO_CFG_CONSTS_VH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_GPIO_2_1_CONFIG 6'h2c
`define IDX_GPIO_2_2_CONFIG 6'h2d
`define IDX_GPIO_2_4_CONFIG 6'h2f
`define IDX_GPIO_2_5_CONFIG 6'h30
`define IDX_GPIO_2_6_CONFIG 6'h31
`define IDX_GPIO_2_7_CONFIG 6'h32
`define IDX_GPIO_3_0_CONFIG 6'h33
`define IDX_GPIO_3_1_CONFIG 6'h34

// ----------------------------------------------------------------
// slots of the configuration store, one per pin
// ----------------------------------------------------------------
`define SLOT_2_1 3'h0
`define SLOT_2_2 3'h1
`define SLOT_2_4 3'h2
`define SLOT_2_5 3'h3
`define SLOT_2_6 3'h4
`define SLOT_2_7 3'h5
`define SLOT_3_0 3'h6
`define SLOT_3_1 3'h7

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define BIT_DIR 0
`define BIT_POL 1
`define BIT_SEL 2
`define BIT_SEL_HI 3
`define BIT_ODRAIN 7
`define CFG_RESET 8'h01
`define MASK_TWO_BIT_SEL 8'h8f
`define MASK_ONE_BIT_SEL 8'h87
`define MASK_NO_SEL 8'h83
`define FSEL_GPIO 2'h0
`define FSEL_KBC 2'h1
`define FSEL_EDGE_INT 2'h2
`define FSEL_HIGH 2'h3

`endif

// ==== rtl/gpio_pin_config_bank.v ====
`timescale 1ns/1ps
`include "gpio_cfg_consts.vh"

// Behaviour
// - bit 0 is direction: 1 input, 0 output.
// - bit 1 inverts the pin value both ways when set.
// - bit 7 picks open-drain when 1, push-pull when 0.
// - every configuration register resets to 0x01.
// - pin 2.1 bits 3:2: legacy int six, edge int 0, kbc bit six, gpio.
// - pin 2.2 bits 3:2: motor select one, edge int 1, kbc bit two, gpio.
// - single-alternate pins: bit 2 set selects the alternate function.
// - pin 2.4 has no alternate; bits 6:2 reserved, gpio only.
// - pin 2.5 bit 2 set makes it the music serial receive input.
// - pin 2.6 bit 2 set makes it the music serial transmit output.
// - pin 2.7 bit 2 set drives the system management interrupt.
// - pin 3.0 bit 2 set makes it the SMBus clock line.
// - pin 3.1 bit 2 set makes it the fan tachometer input.

module gpio_pin_config_bank (
  input wire CLK,
  input wire SRST,
  input wire [7:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  input wire [3:0] BYTEENABLE,
  output reg [31:0] READDATA,
  output reg WAITREQUEST,
  input wire [7:0] PIN_I,
  output wire [7:0] PIN_O,
  output wire [7:0] PIN_OE,
  input wire [7:0] GPIO_OUT_VAL,
  output wire [7:0] GPIO_IN_VAL,
  output wire LEGACY_INT_LINE_SIX,
  output wire [1:0] EDGE_INT_IN,
  input wire KBC_PORT_BIT_SIX_OUT,
  output wire KBC_PORT_BIT_SIX_IN,
  input wire KBC_PORT_BIT_TWO_OUT,
  output wire KBC_PORT_BIT_TWO_IN,
  input wire FLOPPY_MOTOR_SEL_ONE,
  output wire MUSIC_SERIAL_RX,
  input wire MUSIC_SERIAL_TX,
  input wire SYS_MGMT_INT_OUT,
  input wire SMBUS_CLK_OUT,
  output wire SMBUS_CLK_IN,
  output wire FAN_SPEED_SENSE
);

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  reg [7:0] pin_meta_q;
  reg [7:0] pin_sync_q;

  // first stage is read by the second stage only
  always @(posedge CLK) begin
    if (SRST) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= PIN_I;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire [5:0] addr_idx = ADDRESS[7:2];
  wire addr_aligned = (ADDRESS[1:0] == 2'h0);
  reg [2:0] slot;
  reg slot_hit;

  // map register index to a configuration slot; 0x2e is not ours
  always @* begin
    slot = `SLOT_2_1;
    slot_hit = 1'b0;
    case (addr_idx)
      `IDX_GPIO_2_1_CONFIG: begin
        slot = `SLOT_2_1;
        slot_hit = addr_aligned;
      end
      `IDX_GPIO_2_2_CONFIG: begin
        slot = `SLOT_2_2;
        slot_hit = addr_aligned;
      end
      `IDX_GPIO_2_4_CONFIG: begin
        slot = `SLOT_2_4;
        slot_hit = addr_aligned;
      end
      `IDX_GPIO_2_5_CONFIG: begin
        slot = `SLOT_2_5;
        slot_hit = addr_aligned;
      end
      `IDX_GPIO_2_6_CONFIG: begin
        slot = `SLOT_2_6;
        slot_hit = addr_aligned;
      end
      `IDX_GPIO_2_7_CONFIG: begin
        slot = `SLOT_2_7;
        slot_hit = addr_aligned;
      end
      `IDX_GPIO_3_0_CONFIG: begin
        slot = `SLOT_3_0;
        slot_hit = addr_aligned;
      end
      `IDX_GPIO_3_1_CONFIG: begin
        slot = `SLOT_3_1;
        slot_hit = addr_aligned;
      end
      default: begin
        slot = `SLOT_2_1;
        slot_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // writable bit mask per slot
  // ----------------------------------------------------------------
  reg [7:0] wr_mask;

  // reserved bits are never stored, so they read back as zero
  always @* begin
    case (slot)
      `SLOT_2_1: wr_mask = `MASK_TWO_BIT_SEL;
      `SLOT_2_2: wr_mask = `MASK_TWO_BIT_SEL;
      `SLOT_2_4: wr_mask = `MASK_NO_SEL;
      default: wr_mask = `MASK_ONE_BIT_SEL;
    endcase
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // two-phase answer: the first edge of a request loads read data
  // and drops waitrequest; the second edge commits any write and
  // raises it again. costs a cycle but keeps every output a flop.
  wire req = READ | WRITE;
  wire req_take = req & ~WAITREQUEST;
  wire wr_commit = WRITE & req_take & slot_hit & BYTEENABLE[0];

  reg [7:0] cfg_q [0:7];
  wire [31:0] rd_d = slot_hit ? {24'h000000, cfg_q[slot]} : 32'h00000000;

  always @(posedge CLK) begin
    if (SRST) begin
      WAITREQUEST <= 1'b1;
      READDATA <= 32'h00000000;
    end else if (req_take) begin
      WAITREQUEST <= 1'b1;
    end else if (req) begin
      WAITREQUEST <= 1'b0;
      READDATA <= READ ? rd_d : 32'h00000000; // unmapped reads zero
    end else begin
      WAITREQUEST <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // configuration store
  // ----------------------------------------------------------------
  integer i;

  // the reset value selects non-inverted push-pull input gpio
  always @(posedge CLK) begin
    if (SRST) begin
      for (i = 0; i < 8; i = i + 1) begin
        cfg_q[i] <= `CFG_RESET;
      end
    end else if (wr_commit) begin
      cfg_q[slot] <= WRITEDATA[7:0] & wr_mask;
    end
  end

  // ----------------------------------------------------------------
  // function select decode
  // ----------------------------------------------------------------
  wire [1:0] fsel_2_1 = cfg_q[`SLOT_2_1][`BIT_SEL_HI:`BIT_SEL];
  wire [1:0] fsel_2_2 = cfg_q[`SLOT_2_2][`BIT_SEL_HI:`BIT_SEL];

  // pin 2.1: two input alternates and the driven kbc port bit six share one pin
  wire legacy_sel = (fsel_2_1 == `FSEL_HIGH);
  wire edge0_sel = (fsel_2_1 == `FSEL_EDGE_INT);
  wire kbc6_sel = (fsel_2_1 == `FSEL_KBC);

  // pin 2.2: motor select output, edge int input, kbc port bit
  wire motor_sel = (fsel_2_2 == `FSEL_HIGH);
  wire edge1_sel = (fsel_2_2 == `FSEL_EDGE_INT);
  wire kbc2_sel = (fsel_2_2 == `FSEL_KBC);

  // single-alternate pins use bit 2 alone
  wire rx_sel = cfg_q[`SLOT_2_5][`BIT_SEL];
  wire tx_sel = cfg_q[`SLOT_2_6][`BIT_SEL];
  wire smi_sel = cfg_q[`SLOT_2_7][`BIT_SEL];
  wire sclk_sel = cfg_q[`SLOT_3_0][`BIT_SEL];
  wire tach_sel = cfg_q[`SLOT_3_1][`BIT_SEL];

  // per-pin alternate enable, drive and value, slot order
  // kbc port bits and the SMBus clock are driven and read back;
  // the kbc unit and SMBus master drive high to release the line
  wire [7:0] alt_en = {tach_sel, sclk_sel, smi_sel, tx_sel, rx_sel,
                       1'b0,
                       motor_sel | edge1_sel | kbc2_sel,
                       legacy_sel | edge0_sel | kbc6_sel};
  wire [7:0] alt_drv = {1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
                        motor_sel | kbc2_sel, kbc6_sel};
  wire [7:0] alt_val = {1'b0, SMBUS_CLK_OUT, SYS_MGMT_INT_OUT,
                        MUSIC_SERIAL_TX, 1'b0, 1'b0,
                        motor_sel ? FLOPPY_MOTOR_SEL_ONE :
                                    KBC_PORT_BIT_TWO_OUT,
                        KBC_PORT_BIT_SIX_OUT};

  // ----------------------------------------------------------------
  // pin slices
  // ----------------------------------------------------------------
  // idle level of each alternate input while not selected; the
  // SMBus clock rests high like an idle bus
  localparam [7:0] ALT_IDLE = 8'h40;
  wire [7:0] alt_in;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : pin
      gpio_pin_slice #(
        .ALT_IDLE(ALT_IDLE[g])
      ) u_slice (
        .clk(CLK),
        .srst(SRST),
        .cfg(cfg_q[g]),
        .pin_s(pin_sync_q[g]),
        .gpio_val(GPIO_OUT_VAL[g]),
        .alt_en(alt_en[g]),
        .alt_drv(alt_drv[g]),
        .alt_val(alt_val[g]),
        .pin_o(PIN_O[g]),
        .pin_oe(PIN_OE[g]),
        .gpio_in(GPIO_IN_VAL[g]),
        .alt_in(alt_in[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // alternate input routing
  // ----------------------------------------------------------------
  reg legacy_q;
  reg [1:0] edge_q;
  reg kbc6_q;
  reg kbc2_q;

  // split shared synchronised pin inputs by code; unselected outputs stay low
  always @(posedge CLK) begin
    if (SRST) begin
      legacy_q <= 1'b0;
      edge_q <= 2'h0;
      kbc6_q <= 1'b0;
      kbc2_q <= 1'b0;
    end else begin
      legacy_q <= legacy_sel & pin_sync_in(0);
      edge_q[0] <= edge0_sel & pin_sync_in(0);
      kbc6_q <= kbc6_sel & pin_sync_in(0);
      edge_q[1] <= edge1_sel & pin_sync_in(1);
      kbc2_q <= kbc2_sel & pin_sync_in(1);
    end
  end

  // polarity-corrected synchronised pin value for shared pins
  function pin_sync_in;
    input integer n;
    begin
      pin_sync_in = pin_sync_q[n] ^ cfg_q[n][`BIT_POL];
    end
  endfunction

  assign LEGACY_INT_LINE_SIX = legacy_q;
  assign EDGE_INT_IN = edge_q;
  assign KBC_PORT_BIT_SIX_IN = kbc6_q;
  assign KBC_PORT_BIT_TWO_IN = kbc2_q;
  assign MUSIC_SERIAL_RX = alt_in[`SLOT_2_5];
  assign SMBUS_CLK_IN = alt_in[`SLOT_3_0];
  assign FAN_SPEED_SENSE = alt_in[`SLOT_3_1];

endmodule

// ==== rtl/gpio_pin_slice.v ====
`timescale 1ns/1ps
`include "gpio_cfg_consts.vh"

module gpio_pin_slice #(
  parameter ALT_IDLE = 1'b0
) (
  input wire clk,
  input wire srst,
  input wire [7:0] cfg,
  input wire pin_s,
  input wire gpio_val,
  input wire alt_en,
  input wire alt_drv,
  input wire alt_val,
  output reg pin_o,
  output reg pin_oe,
  output reg gpio_in,
  output reg alt_in
);

  // ----------------------------------------------------------------
  // output path
  // ----------------------------------------------------------------
  // source picked by function select, direction by cfg or alt unit
  wire src_val = alt_en ? alt_val : gpio_val;
  wire drive = alt_en ? alt_drv : ~cfg[`BIT_DIR];
  wire out_val = src_val ^ cfg[`BIT_POL];
  wire odrain = cfg[`BIT_ODRAIN];
  // open drain only pulls low, so a high just releases the pin
  wire pin_o_d = odrain ? 1'b0 : out_val;
  wire pin_oe_d = drive & (~odrain | ~out_val);

  // ----------------------------------------------------------------
  // input path
  // ----------------------------------------------------------------
  // input read with the same polarity inversion as the output
  wire in_val = pin_s ^ cfg[`BIT_POL];
  // unselected alternate input rests at its idle level
  wire alt_in_d = alt_en ? in_val : ALT_IDLE;

  // registered so every pin-facing output leaves a flip-flop
  always @(posedge clk) begin
    if (srst) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
      gpio_in <= 1'b0;
      alt_in <= ALT_IDLE;
    end else begin
      pin_o <= pin_o_d;
      pin_oe <= pin_oe_d;
      gpio_in <= in_val;
      alt_in <= alt_in_d;
    end
  end

endmodule

// ==== verif/gpio_cfg_chk_sva.sv ====
`timescale 1ns/1ps
module gpio_cfg_chk (
  input wire CLK,
  input wire SRST,
  input wire [7:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  input wire [3:0] BYTEENABLE,
  input wire [31:0] READDATA,
  input wire WAITREQUEST,
  input wire [7:0] PIN_I,
  input wire [7:0] PIN_O,
  input wire [7:0] PIN_OE,
  input wire [7:0] GPIO_OUT_VAL,
  input wire [7:0] GPIO_IN_VAL,
  input wire LEGACY_INT_LINE_SIX,
  input wire [1:0] EDGE_INT_IN,
  input wire KBC_PORT_BIT_SIX_IN
);
  logic [7:0] cfg_q;
  logic [2:0] up_q;
  // shadow of pin 2.4 config; pin 2.4 has no alternate to muddy drive
  always @(posedge CLK) begin
    if (SRST) begin
      cfg_q <= 8'h01;
      up_q <= 3'h0;
    end else begin
      if (up_q != 3'h7) up_q <= up_q + 3'h1;
      if (WRITE && !WAITREQUEST && BYTEENABLE[0] && ADDRESS == 8'hbc)
        cfg_q <= WRITEDATA[7:0] & 8'h83;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_req;
    (READ || WRITE) && WAITREQUEST;
  endsequence
  sequence s_ack;
    !WAITREQUEST ##1 WAITREQUEST;
  endsequence
  a_bus_ack_once: assert property (s_req |=> s_ack)
    else $error("bus answer not a single cycle");
  a_rsv_zero: assert property (
    READDATA[31:8] == 24'h0 && READDATA[6:4] == 3'h0)
    else $error("reserved read bits not zero");
  a_reset_idle: assert property ($fell(SRST) |-> PIN_OE == 8'h00)
    else $error("pin driven after reset");
  a_pp_drive: assert property (
    !$past(cfg_q[0]) && !$past(cfg_q[7]) |-> PIN_OE[2] &&
    PIN_O[2] == ($past(GPIO_OUT_VAL[2]) ^ $past(cfg_q[1])))
    else $error("push-pull drive wrong");
  a_in_float: assert property ($past(cfg_q[0]) |-> !PIN_OE[2])
    else $error("input pin driven");
  a_od_drive: assert property (
    !$past(cfg_q[0]) && $past(cfg_q[7]) |-> !PIN_O[2] &&
    PIN_OE[2] == !($past(GPIO_OUT_VAL[2]) ^ $past(cfg_q[1])))
    else $error("open-drain drive wrong");
  a_in_invert: assert property (
    up_q == 3'h7 && $past(cfg_q[1], 4) == cfg_q[1] |->
    GPIO_IN_VAL[2] == ($past(PIN_I[2], 3) ^ cfg_q[1]))
    else $error("input polarity wrong");
  a_one_func: assert property (
    !(LEGACY_INT_LINE_SIX && (EDGE_INT_IN[0] || KBC_PORT_BIT_SIX_IN)))
    else $error("two functions on one pin");
endmodule
bind gpio_pin_config_bank gpio_cfg_chk i_chk (.*);

// ==== verif/pin_world.sv ====
`timescale 1ns/1ps
module pin_world (
  input wire [7:0] pin_o,
  input wire [7:0] pin_oe,
  input wire [7:0] ext_lo,
  output logic [7:0] pin_i
);
  // pads float high by pull-up; the device wins a clash with the far side
  always_comb
    for (int n = 0; n < 8; n++)
      pin_i[n] = pin_oe[n] ? pin_o[n] : !ext_lo[n];
endmodule

// ==== verif/test_gpio_pin_config_bank.sv ====
`timescale 1ns/1ps
module test_gpio_pin_config_bank;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [7:0] gout = 8'h00;
  logic [7:0] ext_lo = 8'h00;
  logic [5:0] alt = 6'h3f;
  logic [63:0] masks = 64'h8787878787838f8f;
  wire [31:0] rdata;
  wire [7:0] pi, po, oe, gin;
  wire [1:0] edge_in;
  wire waitreq, legacy, kbc6_in, kbc2_in, rx, sclk_in, fan;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int i;
  logic [31:0] d;
  gpio_pin_config_bank i_dut (.CLK(clk), .SRST(srst), .ADDRESS(addr),
    .READ(rd_en), .WRITE(wr_en), .WRITEDATA(wdata), .BYTEENABLE(4'hf),
    .READDATA(rdata), .WAITREQUEST(waitreq), .PIN_I(pi), .PIN_O(po),
    .PIN_OE(oe), .GPIO_OUT_VAL(gout), .GPIO_IN_VAL(gin),
    .LEGACY_INT_LINE_SIX(legacy), .EDGE_INT_IN(edge_in),
    .KBC_PORT_BIT_SIX_OUT(alt[0]), .KBC_PORT_BIT_SIX_IN(kbc6_in),
    .KBC_PORT_BIT_TWO_OUT(alt[1]), .KBC_PORT_BIT_TWO_IN(kbc2_in),
    .FLOPPY_MOTOR_SEL_ONE(alt[2]), .MUSIC_SERIAL_RX(rx),
    .MUSIC_SERIAL_TX(alt[3]), .SYS_MGMT_INT_OUT(alt[4]),
    .SMBUS_CLK_OUT(alt[5]), .SMBUS_CLK_IN(sclk_in), .FAN_SPEED_SENSE(fan));
  pin_world i_pins (.pin_o(po), .pin_oe(oe), .ext_lo(ext_lo), .pin_i(pi));
  // ----------------------------------------------------------------
  // clock, hang guard, helpers
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;
  // a stuck handshake would otherwise spin forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      summarize;
    end
  end
  function logic [7:0] adr(input int n);
    return (n < 2 ? 8'hb0 : 8'hb4) + 8'(4 * n);
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // write holds until waitrequest low, then pins get time to settle
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, v};
    wr_en <= 1'b1;
    do @(posedge clk); while (waitreq !== 1'b0);
    wr_en <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    do @(posedge clk); while (waitreq !== 1'b0);
    v = rdata;
    rd_en <= 1'b0;
  endtask
  task summarize;
    $display("counts: %0d compares, %0d bad", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      rd(adr(i), d);
      chk(d, 32'h01);
    end
    for (i = 0; i < 8; i++) begin
      wr(adr(i), 8'hff);
      rd(adr(i), d);
      chk(d, {24'h0, masks[8 * i +: 8]});
    end
    wr(8'hb8, 8'hff);
    rd(8'hb8, d);
    chk(d, 32'h0);
    $display("test registers done");
    gout <= 8'h04;
    wr(8'hbc, 8'h00);
    chk({oe[2], po[2]}, 2'b11);
    wr(8'hbc, 8'h02);
    chk({oe[2], po[2]}, 2'b10);
    wr(8'hbc, 8'h82);
    chk({oe[2], po[2]}, 2'b10);
    wr(8'hbc, 8'h80);
    chk({oe[2], po[2]}, 2'b00);
    ext_lo <= 8'h04;
    wr(8'hbc, 8'h01);
    chk(gin[2], 1'b0);
    wr(8'hbc, 8'h03);
    chk(gin[2], 1'b1);
    $display("test pin drive done");
    ext_lo <= 8'h00;
    gout <= 8'h00;
    // every legal code on the shared pins, never a reserved one
    for (i = 0; i < 4; i++) begin
      wr(8'hb0, 8'(i * 4 + 1));
      d = 32'h00008430 >> (4 * i);
      chk({legacy, edge_in[0], kbc6_in, oe[0]}, d & 32'hf);
      wr(8'hb4, 8'(i * 4 + 1));
      d = 32'h00001430 >> (4 * i);
      chk({edge_in[1], kbc2_in, oe[1]}, d & 32'hf);
    end
    $display("test shared pins done");
    for (i = 3; i < 8; i++) wr(adr(i), 8'h05);
    chk({rx, fan, sclk_in, oe[6:4], po[6:4]}, 9'h1ff);
    alt <= 6'h00;
    repeat (3) @(posedge clk);
    chk(po[6:4], 3'h0);
    for (i = 3; i < 8; i++) wr(adr(i), 8'h01);
    chk({rx, fan, sclk_in, oe[7:3]}, 8'h20);
    $display("test single alternates done");
    summarize;
  end
endmodule
